// ===== core/wdt_core.sv
// Windowed watchdog timer with prescaler, postscaler and sleep wake-up
//
// Operation
// R01: Counter runs only from RC oscillator, enabled together.
// R02: Oscillator input treated as nominal 32 kHz.
// R03: Prescaler divides by 32 or 128.
// R04: Prescaler period nominally 1 ms or 4 ms.
// R05: Postscaler selects one of sixteen ratios.
// R06: Any device reset clears all counts.
// R07: Completed clock switch clears all counts.
// R08: Power-save instruction clears all counts.
// R09: Leaving sleep or idle clears all counts.
// R10: Clear instruction in run clears all counts.
// R11: Watchdog keeps counting in sleep or idle.
// R12: Timeout in sleep or idle wakes device.
// R13: Software clears sleep and idle flags itself.
// R14: Timeout flag sticky until software clears it.
// R15: Fixed enable bit forces watchdog always on.
// R16: Otherwise software enable bit controls watchdog.
// R17: Software enable bit cleared by device reset.
// R18: Early clear in window mode causes reset.
// R19: Software clears only in last quarter.
// R20: Prescale select one gives 128, zero 32.
// R21: Postscale code n gives ratio two to n.
// R22: Forced on, software disable has no effect.
// R23: Run-mode timeout resets device, sets flag.
// R24: Period equals prescaler period times postscaler ratio.
`include "wdt_regs.svh"

module wdt_core
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Fixed configuration bits
  input wire logic i_wd_fixed_enable,
  input wire logic i_wd_window_disable,
  input wire logic i_wd_prescale_select,
  input wire logic [3:0] i_wd_postscale_select,
  // Software enable bit write port
  input wire logic i_soft_en_wr,
  input wire logic i_soft_en_wdata,
  // Timeout flag clear from software
  input wire logic i_flag_clr,
  // Core events
  input wire logic i_dev_reset,
  input wire logic i_clk_switch_done,
  input wire logic i_power_save_instr,
  input wire logic i_wake_event,
  input wire logic i_wd_clear_instr,
  // Status and results
  output logic o_low_power_rc_osc_en,
  output logic o_wd_soft_enable,
  output logic o_wd_timeout_flag,
  output logic o_in_power_save,
  output logic o_wd_reset,
  output logic o_wake
);

  localparam logic [8:0] OSC_LAST = 9'(`WD_OSC_DIV_CYC - 1);

  wdt_state_e state_r, state_nxt;
  wdt_count_t cnt_r, cnt_nxt;
  logic [8:0] osc_div_r, osc_div_nxt;
  logic soft_en_r, soft_en_nxt;
  logic flag_r, flag_nxt;
  logic wd_reset_r, wd_reset_nxt;
  logic wake_r, wake_nxt;

  logic en_w;
  logic tick_w;
  logic [4:0] exp_w;
  logic [22:0] period_w;
  wdt_count_t term_w;
  logic [22:0] qstart_w;
  logic early_w;
  logic early_err_w;
  logic exit_w;
  logic clr_w;
  logic timeout_w;

  // Enable: fixed bit overrides the software bit
  assign en_w = i_wd_fixed_enable | soft_en_r; // R15 R16 R22

  // The oscillator runs exactly when the watchdog is enabled
  assign o_low_power_rc_osc_en = en_w; // R01

  // Oscillator tick, one per nominal 32 kHz period
  assign tick_w = en_w & (osc_div_r == OSC_LAST); // R02

  // Period exponent: prescaler width plus postscaler code
  always_comb
  begin
    exp_w = (i_wd_prescale_select ? 5'(`WD_PRE_EXP_LONG)
                                  : 5'(`WD_PRE_EXP_SHORT)); // R03 R20 R04
    exp_w = exp_w + {1'b0, i_wd_postscale_select}; // R05 R21
    period_w = 23'h000001 << exp_w; // R24
    term_w = period_w[21:0] - 22'h000001;
    qstart_w = period_w - (period_w >> 2);
  end

  // Window check: clearing before the last quarter is early
  assign early_w = ({1'b0, cnt_r} < qstart_w);
  assign early_err_w = en_w & (state_r == WDT_ST_RUN) & i_wd_clear_instr
                       & ~i_wd_window_disable & early_w; // R18

  // Leaving sleep or idle on another wake source
  assign exit_w = (state_r == WDT_ST_SAVE) & i_wake_event;

  // Every cause that clears the prescaler and postscaler together
  assign clr_w = i_dev_reset | wd_reset_r // R06
                 | i_clk_switch_done // R07
                 | (i_power_save_instr & (state_r == WDT_ST_RUN)) // R08
                 | exit_w // R09
                 | (i_wd_clear_instr & (state_r == WDT_ST_RUN)) // R10
                 | ~en_w; // R01

  // Timeout when the count reaches the selected period; a clear wins
  assign timeout_w = tick_w & (cnt_r == term_w) & ~clr_w; // R24

  // Count next values; the count keeps running in sleep or idle
  always_comb
  begin
    osc_div_nxt = osc_div_r;
    cnt_nxt = cnt_r;
    if (clr_w)
    begin
      osc_div_nxt = 9'h000;
      cnt_nxt = '0;
    end
    else if (tick_w)
    begin
      osc_div_nxt = 9'h000;
      cnt_nxt = timeout_w ? '0 : cnt_r + 22'h000001; // R11
    end
    else
    begin
      osc_div_nxt = osc_div_r + 9'h001;
    end
  end

  // Count registers
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      osc_div_r <= 9'h000;
      cnt_r <= '0; // R06
    end
    else
    begin
      osc_div_r <= osc_div_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Run and power-save state next value
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      WDT_ST_RUN:
      begin
        if (i_power_save_instr && !i_dev_reset && !wd_reset_r)
        begin
          state_nxt = WDT_ST_SAVE;
        end
      end
      WDT_ST_SAVE:
      begin
        if (i_dev_reset || wd_reset_r || i_wake_event || timeout_w)
        begin
          state_nxt = WDT_ST_RUN; // R12
        end
      end
      default:
      begin
        state_nxt = WDT_ST_RUN;
      end
    endcase
  end

  // Software enable, flag and result pulses next values
  always_comb
  begin
    soft_en_nxt = soft_en_r;
    if (i_dev_reset || wd_reset_r)
    begin
      soft_en_nxt = `WD_SOFT_EN_RST; // R17
    end
    else if (i_soft_en_wr)
    begin
      soft_en_nxt = i_soft_en_wdata; // R16
    end
    // Set wins over a clear arriving in the same cycle
    flag_nxt = timeout_w | (flag_r & ~i_flag_clr); // R14 R23
    // A reset issued here is a device reset for the next cycle
    wd_reset_nxt = early_err_w | (timeout_w & (state_r == WDT_ST_RUN)); // R18 R23
    wake_nxt = timeout_w & (state_r == WDT_ST_SAVE); // R12
  end

  // Control registers; the flag survives resets other than power-on
  always_ff @(posedge i_clk)
  begin
    if (!i_nrst)
    begin
      state_r <= WDT_ST_RUN;
      soft_en_r <= `WD_SOFT_EN_RST; // R17
      flag_r <= `WD_FLAG_RST;
      wd_reset_r <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      soft_en_r <= soft_en_nxt;
      flag_r <= flag_nxt;
      wd_reset_r <= wd_reset_nxt;
      wake_r <= wake_nxt;
    end
  end

  // Outputs from registers
  assign o_wd_soft_enable = soft_en_r;
  assign o_wd_timeout_flag = flag_r;
  assign o_in_power_save = (state_r == WDT_ST_SAVE);
  assign o_wd_reset = wd_reset_r;
  assign o_wake = wake_r;

  // Checks on the watchdog behaviour
  default clocking wdt_cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  fixed_on_a: assert property (i_wd_fixed_enable |-> o_low_power_rc_osc_en) // R15
    else $error("fixed enable did not keep oscillator on");

  soft_off_a: assert property (i_wd_fixed_enable && i_soft_en_wr && !i_soft_en_wdata
    |=> o_low_power_rc_osc_en || !i_wd_fixed_enable) // R22
    else $error("software disable stopped a forced watchdog");

  soft_rst_a: assert property (i_dev_reset |=> !o_wd_soft_enable) // R17
    else $error("device reset left software enable set");

  flag_hold_a: assert property (o_wd_timeout_flag && !i_flag_clr
    |=> o_wd_timeout_flag) // R14
    else $error("timeout flag cleared without software");

  run_timeout_a: assert property (timeout_w && state_r == WDT_ST_RUN
    |=> o_wd_reset && o_wd_timeout_flag ##1 !o_wd_soft_enable) // R23
    else $error("run timeout did not reset and flag");

  window_a: assert property (early_err_w |=> o_wd_reset ##1 cnt_r == '0) // R18
    else $error("early clear in window mode did not reset");

  clear_instr_a: assert property (i_wd_clear_instr && state_r == WDT_ST_RUN
    |=> cnt_r == '0 && osc_div_r == 9'h000) // R10
    else $error("clear instruction did not clear counts");

  save_enter_a: assert property (state_r == WDT_ST_RUN && i_power_save_instr
    && !i_dev_reset && !wd_reset_r |=> o_in_power_save && cnt_r == '0) // R08
    else $error("power-save entry did not clear counts");

  wake_a: assert property (state_r == WDT_ST_SAVE && timeout_w
    |=> o_wake && !o_in_power_save && !o_wd_reset) // R12
    else $error("sleep timeout did not wake the device");

  save_count_a: assert property (state_r == WDT_ST_SAVE && tick_w && !clr_w
    && !timeout_w |=> cnt_r == $past(cnt_r) + 22'h000001) // R11
    else $error("count stalled during sleep or idle");

  off_hold_a: assert property (!en_w |=> cnt_r == '0 && osc_div_r == 9'h000) // R01
    else $error("count moved while disabled");

  tick_gap_a: assert property (tick_w && !clr_w
    |=> !tick_w [*8]) // R02
    else $error("oscillator ticks too close together");

  switch_a: assert property (i_clk_switch_done |=> cnt_r == '0) // R07
    else $error("clock switch did not clear counts");

  // Clears and restarts that software and the core rely on
  wake_exit_a: assert property (exit_w |=> !o_in_power_save && cnt_r == '0) // R09
    else $error("wake event did not restart the count");

  dev_reset_a: assert property (i_dev_reset |=> cnt_r == '0 && !o_in_power_save) // R06
    else $error("device reset did not clear counts");

  flag_clr_a: assert property (i_flag_clr && !timeout_w |=> !o_wd_timeout_flag) // R14
    else $error("software clear left the timeout flag set");

  soft_write_a: assert property (i_soft_en_wr && !i_dev_reset && !wd_reset_r
    |=> o_wd_soft_enable == $past(i_soft_en_wdata)) // R16
    else $error("software enable write was lost");

  // Main scenarios
  run_timeout_c: cover property (timeout_w && state_r == WDT_ST_RUN);
  save_wake_c: cover property (state_r == WDT_ST_SAVE ##1 o_wake);
  window_err_c: cover property (early_err_w);
  late_clear_c: cover property (i_wd_clear_instr && !early_w && !i_wd_window_disable);
  long_post_c: cover property (timeout_w && i_wd_postscale_select != 4'h0);

endmodule

// ===== shared/wdt_pkg.sv
// Types shared by the windowed watchdog design
package wdt_pkg;

  // Run state versus sleep or idle
  typedef enum logic {WDT_ST_RUN, WDT_ST_SAVE} wdt_state_e;

  // Combined prescaler and postscaler count
  typedef logic [21:0] wdt_count_t;

endpackage

// ===== shared/wdt_regs.svh
// Timing constants, field widths and reset values of the windowed watchdog
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

// Core clock period and nominal low-power RC oscillator rate
`define WD_CLK_NS 100
`define WD_OSC_KHZ 32
// Core clock cycles per oscillator period, rounded down (31.25 us / 100 ns)
`define WD_OSC_DIV_CYC ((1000000 / `WD_OSC_KHZ) / `WD_CLK_NS)

// Prescaler widths: 5 bits for divide-by-32, 7 bits for divide-by-128
`define WD_PRE_EXP_SHORT 5
`define WD_PRE_EXP_LONG 7
// Nominal prescaler periods in ms at 32 kHz
`define WD_PRE_SHORT_MS 1
`define WD_PRE_LONG_MS 4

// Postscaler select field: four bits, code n gives ratio 2**n
`define WD_POST_W 4
// Combined prescaler and postscaler count width (7 + 15)
`define WD_CNT_W 22

// Reset values
`define WD_SOFT_EN_RST 1'b0
`define WD_FLAG_RST 1'b0

`endif

// ===== test/wdt_core_tb_top.sv
// Self-checking bench for the windowed watchdog core
`include "wdt_regs.svh"

module wdt_core_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Pulse driver event codes and shortest periods in core cycles
  localparam int CLR = 0, CSW = 1, PSV = 2, WEV = 3, DRS = 4, FCL = 5, SEN = 6, SDI = 7;
  localparam int P5 = `WD_OSC_DIV_CYC << `WD_PRE_EXP_SHORT;
  localparam int P7 = `WD_OSC_DIV_CYC << `WD_PRE_EXP_LONG;
  typedef struct {int kind; int cyc; logic flag;} wdt_note_s;
  logic i_clk, i_nrst, i_wd_fixed_enable, i_wd_window_disable, i_wd_prescale_select;
  logic [3:0] i_wd_postscale_select;
  logic i_soft_en_wr, i_soft_en_wdata, i_flag_clr, i_dev_reset, i_clk_switch_done;
  logic i_power_save_instr, i_wake_event, i_wd_clear_instr;
  logic o_low_power_rc_osc_en, o_wd_soft_enable, o_wd_timeout_flag;
  logic o_in_power_save, o_wd_reset, o_wake;
  wdt_note_s q[$];
  wdt_note_s nt;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] seed = 32'h3DBD;

  wdt_core i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_wd_fixed_enable(i_wd_fixed_enable),
    .i_wd_window_disable(i_wd_window_disable), .i_wd_prescale_select(i_wd_prescale_select),
    .i_wd_postscale_select(i_wd_postscale_select), .i_soft_en_wr(i_soft_en_wr),
    .i_soft_en_wdata(i_soft_en_wdata), .i_flag_clr(i_flag_clr), .i_dev_reset(i_dev_reset),
    .i_clk_switch_done(i_clk_switch_done), .i_power_save_instr(i_power_save_instr),
    .i_wake_event(i_wake_event), .i_wd_clear_instr(i_wd_clear_instr),
    .o_low_power_rc_osc_en(o_low_power_rc_osc_en), .o_wd_soft_enable(o_wd_soft_enable),
    .o_wd_timeout_flag(o_wd_timeout_flag), .o_in_power_save(o_in_power_save),
    .o_wd_reset(o_wd_reset), .o_wake(o_wake));

  // 10 MHz core clock and an edge counter used to time results
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) cyc <= cyc + 1;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic check_int(input string nm, input int e, input int g);
    check_count++;
    if (g != e)
    begin
      n_errors++;
      $display("ERROR %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  // One-cycle event pulse; t is the edge count just before the driving edge
  task automatic pulse(input int sel, output int t);
    @(posedge i_clk);
    t = cyc;
    case (sel)
      CLR: i_wd_clear_instr <= 1'b1;
      CSW: i_clk_switch_done <= 1'b1;
      PSV: i_power_save_instr <= 1'b1;
      WEV: i_wake_event <= 1'b1;
      DRS: i_dev_reset <= 1'b1;
      FCL: i_flag_clr <= 1'b1;
      default:
      begin
        i_soft_en_wr <= 1'b1;
        i_soft_en_wdata <= (sel == SEN);
      end
    endcase
    @(posedge i_clk);
    {i_wd_clear_instr, i_clk_switch_done, i_power_save_instr, i_wake_event} <= 4'h0;
    {i_dev_reset, i_flag_clr, i_soft_en_wr, i_soft_en_wdata} <= 4'h0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic settle();
    @(negedge i_clk);
  endtask

  // Result lands on the edge after the event edge, seen at the next falling edge
  task automatic note(input int kind, input int at, input logic flag);
    q.push_back('{kind, at, flag});
  endtask

  // Bounded wait until every noted result has been seen
  task automatic drain(input int lim);
    int i = 0;
    while (q.size() > 0 && i < lim)
    begin
      @(posedge i_clk);
      i++;
    end
    check_int("pending results", 0, q.size());
    if (q.size() > 0)
      finish_test();
  endtask

  // Each result pulse consumes the oldest expectation
  always @(negedge i_clk)
  begin
    if (i_nrst === 1'b1 && (o_wd_reset === 1'b1 || o_wake === 1'b1))
    begin
      if (q.size() == 0)
        check_int("unexpected pulse", 0, 1);
      else
      begin
        nt = q.pop_front();
        check_int("pulse kind", nt.kind, int'(o_wake === 1'b1));
        check_int("pulse cycle", nt.cyc, cyc);
        check_bit("timeout flag", nt.flag, o_wd_timeout_flag);
      end
    end
  end

  // Hang guard, about ten percent above the longest legal run
  initial
  begin
    idle(99000);
    check_int("run limit", 0, 1);
    finish_test();
  end

  initial
  begin
    int t;
    int p;
    {i_nrst, i_wd_fixed_enable, i_wd_prescale_select, i_wd_postscale_select} = 7'h00;
    {i_soft_en_wr, i_soft_en_wdata, i_flag_clr, i_dev_reset} = 4'h0;
    {i_clk_switch_done, i_power_save_instr, i_wake_event, i_wd_clear_instr} = 4'h0;
    i_wd_window_disable = 1'b1;
    idle(10);
    i_nrst <= 1'b1;
    settle();
    check_bit("soft enable", 1'b0, o_wd_soft_enable);
    check_bit("flag", 1'b0, o_wd_timeout_flag);
    check_bit("osc enable", 1'b0, o_low_power_rc_osc_en);
    $display("test reset done");
    // Forced on: a software disable must not stop the oscillator
    @(posedge i_clk);
    i_wd_fixed_enable <= 1'b1;
    pulse(SDI, t);
    settle();
    check_bit("osc enable", 1'b1, o_low_power_rc_osc_en);
    @(posedge i_clk);
    i_wd_fixed_enable <= 1'b0;
    pulse(SEN, t);
    settle();
    check_bit("osc enable", 1'b1, o_low_power_rc_osc_en);
    $display("test enable done");
    // A second clear restarts the period; run timeout resets and flags
    pulse(CLR, t);
    seed = lfsr(seed);
    idle(7700 + int'(seed[9:0]));
    // Window mode from here on; this clear lands in the last quarter
    @(posedge i_clk);
    i_wd_window_disable <= 1'b0;
    pulse(CLR, t);
    note(0, t + P5 + 2, 1'b1);
    drain(P5 + 10);
    settle();
    check_bit("soft enable", 1'b0, o_wd_soft_enable);
    pulse(DRS, t);
    settle();
    check_bit("flag", 1'b1, o_wd_timeout_flag);
    pulse(FCL, t);
    settle();
    check_bit("flag", 1'b0, o_wd_timeout_flag);
    $display("test run timeout done");
    // Counting goes on in sleep, clears there are ignored, timeout wakes
    pulse(SEN, t);
    pulse(PSV, t);
    note(1, t + P5 + 2, 1'b1);
    settle();
    check_bit("power save", 1'b1, o_in_power_save);
    idle(3000);
    pulse(CLR, t);
    drain(P5);
    settle();
    check_bit("power save", 1'b0, o_in_power_save);
    $display("test sleep wake done");
    // Leaving sleep by another source restarts a period of random postscale
    seed = lfsr(seed);
    p = int'(seed[0]);
    @(posedge i_clk);
    i_wd_postscale_select <= 4'(p);
    pulse(FCL, t);
    pulse(PSV, t);
    seed = lfsr(seed);
    idle(500 + int'(seed[9:0]));
    pulse(WEV, t);
    note(0, t + (P5 << p) + 2, 1'b1);
    drain((P5 << p) + 10);
    $display("test wake event done");
    // Divide-by-128 period measured from a completed clock switch
    @(posedge i_clk);
    i_wd_prescale_select <= 1'b1;
    i_wd_postscale_select <= 4'h0;
    pulse(FCL, t);
    pulse(SEN, t);
    pulse(CSW, t);
    note(0, t + P7 + 2, 1'b1);
    drain(P7 + 10);
    $display("test long prescale done");
    // Window mode: a clear right after the restart is early
    @(posedge i_clk);
    i_wd_prescale_select <= 1'b0;
    i_wd_window_disable <= 1'b0;
    pulse(FCL, t);
    pulse(SEN, t);
    pulse(CLR, t);
    note(0, t + 2, 1'b0);
    drain(20);
    settle();
    check_bit("soft enable", 1'b0, o_wd_soft_enable);
    $display("test window done");
    finish_test();
  end
endmodule
